// [design/pes_pkg.sv]
// Package of constants and types for the program execute sequencer
package pes_pkg;

    // ****************************************************************
    // Sizes and limits
    // ****************************************************************
    localparam int PES_LINE_MAX = 35;
    localparam int PES_LEN_W = 6;
    localparam int PES_LNUM_W = 10;
    localparam int PES_LNUM_MAX = 999;
    localparam int PES_PC_W = 11;
    localparam int PES_MNEM_W = 3;

    // ****************************************************************
    // Command classes
    // ****************************************************************
    typedef enum logic [3:0]
    {
        PES_CMD_OTHER,
        PES_CMD_NUMERIC,
        PES_CMD_PROG,
        PES_CMD_EXECUTE,
        PES_CMD_RUN,
        PES_CMD_STEP,
        PES_CMD_STOP,
        PES_CMD_NEXT,
        PES_CMD_EDIT
    } pes_cmd_e;

    // ****************************************************************
    // Processor modes
    // ****************************************************************
    typedef enum logic [2:0]
    {
        PES_ST_IDLE,
        PES_ST_ENTRY,
        PES_ST_EDIT,
        PES_ST_RUN,
        PES_ST_STEP
    } pes_state_e;

    // Line length, line number and program position when reset
    localparam logic [PES_LEN_W-1:0] PES_LEN_RST = 6'h00;
    localparam logic [PES_LNUM_W-1:0] PES_LNUM_RST = 10'h000;
    localparam logic [PES_PC_W-1:0] PES_PC_RST = 11'h000;

endpackage : pes_pkg

// [design/pes_cmd_if.sv]
// Interface that carries one command between sequencer sub-blocks
`timescale 1ns/1ps
interface pes_cmd_if;
    import pes_pkg::*;

    logic valid;
    pes_cmd_e cmd;
    logic [pes_pkg::PES_MNEM_W-1:0] len;
    logic stored;

    modport src
    (
        output valid,
        output cmd,
        output len,
        output stored
    );
    modport dst
    (
        input valid,
        input cmd,
        input len,
        input stored
    );
endinterface : pes_cmd_if

// [design/pes_cmd_arb.sv]
// Command source arbiter: direct (keyboard or GPIB) over stored program
`timescale 1ns/1ps
module pes_cmd_arb
    import pes_pkg::*;
(
    // Direct command source
    input wire logic dir_valid,
    input wire pes_cmd_e dir_cmd,
    input wire logic [PES_MNEM_W-1:0] dir_len,
    // Stored command source
    input wire logic prg_valid,
    input wire pes_cmd_e prg_cmd,
    input wire logic [PES_MNEM_W-1:0] prg_len,
    // Stored fetch allowed
    input wire logic prg_allow,
    // Selected command
    pes_cmd_if.src sel,
    output logic prg_taken
);

    // ****************************************************************
    // Selection
    // ****************************************************************
    // Direct commands win; stored ones only when fetch is allowed
    always_comb
    begin
        sel.valid = 1'b0;
        sel.cmd = PES_CMD_OTHER;
        sel.len = '0;
        sel.stored = 1'b0;
        prg_taken = 1'b0;
        if (dir_valid)
        begin
            sel.valid = 1'b1;
            sel.cmd = dir_cmd;
            sel.len = dir_len;
        end
        else if (prg_valid && prg_allow)
        begin
            sel.valid = 1'b1;
            sel.cmd = prg_cmd;
            sel.len = prg_len;
            sel.stored = 1'b1;
            prg_taken = 1'b1;
        end
    end

endmodule : pes_cmd_arb

// [design/pes_line_fmt.sv]
// Program line formatter: spacing, length limit and line numbering
`timescale 1ns/1ps
module pes_line_fmt
    import pes_pkg::*;
#(
    parameter int LINE_MAX = PES_LINE_MAX
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Entry command
    pes_cmd_if.dst ent,
    input wire logic ent_active,
    // Outputs
    output logic [PES_LEN_W-1:0] line_len,
    output logic [PES_LNUM_W-1:0] line_num,
    output logic line_close,
    output logic line_wrap_warn,
    output logic sep_space,
    output logic line_empty
);

    logic [PES_LEN_W-1:0] len_q;
    logic [PES_LEN_W-1:0] len_d;
    logic [PES_LNUM_W-1:0] num_q;
    logic [PES_LNUM_W-1:0] num_d;
    logic last_num_q;
    logic last_num_d;
    logic close_q;
    logic close_d;
    logic warn_q;
    logic warn_d;
    logic space_q;
    logic space_d;

    // Line width after adding a command, with its leading space if any
    function automatic logic [PES_LEN_W-1:0] add_w(
        input logic [PES_LEN_W-1:0] cur,
        input logic [PES_MNEM_W-1:0] mlen,
        input logic sp
    );
        add_w = cur + PES_LEN_W'(mlen) + PES_LEN_W'(sp);
    endfunction : add_w

    // ****************************************************************
    // Line building
    // ****************************************************************
    // Next line length, number, spacing and wrap warning
    always_comb
    begin
        logic sp;
        logic is_num;
        sp = 1'b0;
        is_num = (ent.cmd == PES_CMD_NUMERIC);
        len_d = len_q;
        num_d = num_q;
        last_num_d = last_num_q;
        close_d = 1'b0;
        warn_d = 1'b0;
        space_d = 1'b0;
        if (ent_active && ent.valid)
        begin
            if (ent.cmd == PES_CMD_NEXT)
            begin
                if (len_q != PES_LEN_RST)
                begin
                    close_d = 1'b1;
                    len_d = PES_LEN_RST;
                    last_num_d = 1'b0;
                    if (num_q != PES_LNUM_W'(PES_LNUM_MAX))
                        num_d = num_q + 1'b1;
                end
            end
            else if (ent.cmd != PES_CMD_EXECUTE && ent.cmd != PES_CMD_EDIT)
            begin
                // EXECUTE and EDIT leave the line alone; every other command, RUN, STEP, STOP and PROG included, counts
                sp = (len_q != PES_LEN_RST) && !(is_num && last_num_q);
                if (add_w(len_q, ent.len, sp) > PES_LEN_W'(LINE_MAX))
                begin
                    close_d = 1'b1;
                    warn_d = 1'b1;
                    len_d = add_w(PES_LEN_RST, ent.len, 1'b0);
                    if (num_q != PES_LNUM_W'(PES_LNUM_MAX))
                        num_d = num_q + 1'b1;
                end
                else
                begin
                    space_d = sp;
                    len_d = add_w(len_q, ent.len, sp);
                end
                last_num_d = is_num;
            end
        end
    end

    // Registers of the line builder
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            len_q <= PES_LEN_RST;
            num_q <= PES_LNUM_RST;
            last_num_q <= 1'b0;
            close_q <= 1'b0;
            warn_q <= 1'b0;
            space_q <= 1'b0;
        end
        else
        begin
            len_q <= len_d;
            num_q <= num_d;
            last_num_q <= last_num_d;
            close_q <= close_d;
            warn_q <= warn_d;
            space_q <= space_d;
        end
    end

    // Outputs
    assign line_len = len_q;
    assign line_num = num_q;
    assign line_close = close_q;
    assign line_wrap_warn = warn_q;
    assign sep_space = space_q;
    assign line_empty = (len_q == PES_LEN_RST);

endmodule : pes_line_fmt

// [design/pes_seq.sv]
// Top of the program execute sequencer
`timescale 1ns/1ps
module pes_seq
    import pes_pkg::*;
#(
    parameter int LINE_MAX = PES_LINE_MAX
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Direct commands from keyboard or GPIB
    input wire logic dir_valid,
    input wire pes_cmd_e dir_cmd,
    input wire logic [PES_MNEM_W-1:0] dir_len,
    // Stored program commands
    input wire logic prg_valid,
    input wire pes_cmd_e prg_cmd,
    input wire logic [PES_MNEM_W-1:0] prg_len,
    output logic prg_ready,
    output logic [PES_PC_W-1:0] prg_pos,
    input wire logic prog_stored,
    // Execution events
    input wire logic exec_error,
    input wire logic exec_warn,
    // Command execution and status
    output logic exec_valid,
    output pes_cmd_e exec_cmd,
    output logic exec_stored,
    output logic store_valid,
    output pes_cmd_e store_cmd,
    output logic store_space,
    output pes_state_e mode,
    output logic busy,
    output logic [PES_LEN_W-1:0] line_len,
    output logic [PES_LNUM_W-1:0] line_num,
    output logic line_close,
    output logic line_warn
);

    pes_state_e state_q;
    pes_state_e state_d;
    logic [PES_PC_W-1:0] pc_q;
    logic [PES_PC_W-1:0] pc_d;
    logic step_go_q;
    logic step_go_d;
    logic ex_v_q;
    logic ex_v_d;
    pes_cmd_e ex_c_q;
    pes_cmd_e ex_c_d;
    logic ex_s_q;
    logic ex_s_d;
    logic st_v_q;
    logic st_v_d;
    pes_cmd_e st_c_q;
    pes_cmd_e st_c_d;
    logic prg_allow;
    logic prg_taken;
    logic ent_active;
    logic fmt_space;
    logic fmt_empty;
    pes_cmd_if cmd_sel ();

    // ****************************************************************
    // Command source selection
    // ****************************************************************
    // Stored fetch only in run, or in step while a step is pending
    assign prg_allow = (state_q == PES_ST_RUN) ||
                       ((state_q == PES_ST_STEP) && step_go_q);

    pes_cmd_arb u_arb
    (
        .dir_valid(dir_valid),
        .dir_cmd(dir_cmd),
        .dir_len(dir_len),
        .prg_valid(prg_valid),
        .prg_cmd(prg_cmd),
        .prg_len(prg_len),
        .prg_allow(prg_allow),
        .sel(cmd_sel.src),
        .prg_taken(prg_taken)
    );

    assign prg_ready = prg_allow && !dir_valid;

    // ****************************************************************
    // Line formatter
    // ****************************************************************
    assign ent_active = (state_q == PES_ST_ENTRY) ||
                        (state_q == PES_ST_EDIT);

    pes_line_fmt #(.LINE_MAX(LINE_MAX)) u_fmt
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ent(cmd_sel.dst),
        .ent_active(ent_active),
        .line_len(line_len),
        .line_num(line_num),
        .line_close(line_close),
        .line_wrap_warn(line_warn),
        .sep_space(fmt_space),
        .line_empty(fmt_empty)
    );

    // ****************************************************************
    // Mode state machine
    // ****************************************************************
    // Next mode, program position and command issue
    always_comb
    begin
        state_d = state_q;
        pc_d = pc_q;
        step_go_d = step_go_q;
        ex_v_d = 1'b0;
        ex_c_d = cmd_sel.cmd;
        ex_s_d = cmd_sel.stored;
        st_v_d = 1'b0;
        st_c_d = cmd_sel.cmd;
        if (prg_taken)
            pc_d = pc_q + 1'b1;
        case (state_q)
            PES_ST_IDLE:
            begin
                if (cmd_sel.valid)
                begin
                    case (cmd_sel.cmd)
                        PES_CMD_RUN:
                        begin
                            if (prog_stored)
                            begin
                                state_d = PES_ST_RUN;
                                pc_d = PES_PC_RST;
                            end
                        end
                        PES_CMD_STEP:
                        begin
                            if (prog_stored)
                            begin
                                state_d = PES_ST_STEP;
                                step_go_d = 1'b1;
                            end
                        end
                        PES_CMD_PROG:
                            state_d = prog_stored ? PES_ST_EDIT
                                                  : PES_ST_ENTRY;
                        default:
                            ex_v_d = 1'b1;
                    endcase
                end
            end
            PES_ST_ENTRY, PES_ST_EDIT:
            begin
                if (cmd_sel.valid)
                begin
                    case (cmd_sel.cmd)
                        PES_CMD_EXECUTE:
                            state_d = PES_ST_IDLE;
                        PES_CMD_NEXT, PES_CMD_EDIT:
                            state_d = PES_ST_EDIT;
                        default:
                        begin
                            state_d = PES_ST_ENTRY;
                            st_v_d = 1'b1;
                        end
                    endcase
                end
            end
            PES_ST_RUN, PES_ST_STEP:
            begin
                if (cmd_sel.valid && !cmd_sel.stored)
                begin
                    if (cmd_sel.cmd == PES_CMD_STOP)
                    begin
                        state_d = PES_ST_IDLE;
                        step_go_d = 1'b0;
                    end
                end
                else if (cmd_sel.valid)
                begin
                    ex_v_d = 1'b1;
                    if (state_q == PES_ST_STEP)
                        step_go_d = 1'b0;
                    if (cmd_sel.cmd == PES_CMD_STOP)
                        state_d = PES_ST_IDLE;
                end
                if (exec_error ||
                    (exec_warn && state_q == PES_ST_STEP))
                begin
                    state_d = PES_ST_IDLE;
                    step_go_d = 1'b0;
                end
            end
            default:
                state_d = PES_ST_IDLE;
        endcase
        // A direct STEP while waiting in step state runs one more
        if (state_q == PES_ST_STEP && dir_valid &&
            dir_cmd == PES_CMD_STEP && !exec_error && !exec_warn)
            step_go_d = 1'b1;
    end

    // Registers of the mode machine
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_q <= PES_ST_IDLE;
            pc_q <= PES_PC_RST;
            step_go_q <= 1'b0;
            ex_v_q <= 1'b0;
            ex_c_q <= PES_CMD_OTHER;
            ex_s_q <= 1'b0;
            st_v_q <= 1'b0;
            st_c_q <= PES_CMD_OTHER;
        end
        else
        begin
            state_q <= state_d;
            pc_q <= pc_d;
            step_go_q <= step_go_d;
            ex_v_q <= ex_v_d;
            ex_c_q <= ex_c_d;
            ex_s_q <= ex_s_d;
            st_v_q <= st_v_d;
            st_c_q <= st_c_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign exec_valid = ex_v_q;
    assign exec_cmd = ex_c_q;
    assign exec_stored = ex_s_q;
    assign store_valid = st_v_q;
    assign store_cmd = st_c_q;
    assign store_space = fmt_space;
    assign mode = state_q;
    assign busy = (state_q == PES_ST_RUN) || step_go_q;
    assign prg_pos = pc_q;

endmodule : pes_seq

// [verification/pes_seq_properties.sv]
// Port-level checks of the program execute sequencer
`timescale 1ns/1ps
module pes_seq_properties
    import pes_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Command inputs
    input wire logic dir_valid,
    input wire pes_cmd_e dir_cmd,
    input wire logic prg_valid,
    input wire pes_cmd_e prg_cmd,
    input wire logic prog_stored,
    input wire logic exec_error,
    input wire logic exec_warn,
    // Design outputs
    input wire logic prg_ready,
    input wire logic [PES_PC_W-1:0] prg_pos,
    input wire logic exec_valid,
    input wire logic exec_stored,
    input wire pes_state_e mode,
    input wire logic line_close,
    input wire logic line_warn
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic exe;
    logic take;
    logic idle_go;
    // Execution state, stored take and a clean start from idle
    assign exe = (mode == PES_ST_RUN) || (mode == PES_ST_STEP);
    assign take = prg_valid && prg_ready;
    assign idle_go = mode == PES_ST_IDLE && dir_valid && prog_stored &&
        !exec_error && !exec_warn;

    a_run_gated: assert property (
        mode == PES_ST_IDLE && dir_valid && !prog_stored &&
        dir_cmd inside {PES_CMD_RUN, PES_CMD_STEP} |=> mode == PES_ST_IDLE)
        else $error("execution started without a program");
    a_run_enter: assert property (
        idle_go && dir_cmd == PES_CMD_RUN |=> mode == PES_ST_RUN)
        else $error("RUN did not enter run state");
    a_step_enter: assert property (
        idle_go && dir_cmd == PES_CMD_STEP |=> mode == PES_ST_STEP)
        else $error("STEP did not enter step state");
    a_exec_to_idle: assert property (
        mode inside {PES_ST_ENTRY, PES_ST_EDIT} && dir_valid &&
        dir_cmd == PES_CMD_EXECUTE |=> mode == PES_ST_IDLE)
        else $error("EXECUTE did not reach idle");
    a_idle_no_fetch: assert property (!exe |-> !take)
        else $error("stored command taken outside execution");
    a_direct_ignored: assert property (
        exe && dir_valid && !(dir_cmd inside {PES_CMD_STOP, PES_CMD_STEP})
        |=> !(exec_valid && !exec_stored))
        else $error("direct command executed while running");
    a_stop_idle: assert property (
        exe && ((dir_valid && dir_cmd == PES_CMD_STOP) ||
        (take && prg_cmd == PES_CMD_STOP)) |=> mode == PES_ST_IDLE)
        else $error("STOP did not return to idle");
    a_fault_idle: assert property (
        exe && (exec_error || (mode == PES_ST_STEP && exec_warn))
        |=> mode == PES_ST_IDLE)
        else $error("error or step warning did not return to idle");
    a_wrap_closes: assert property (line_warn |-> line_close)
        else $error("wrap warning without line close");
    a_pos_advance: assert property (
        take |=> prg_pos == $past(prg_pos) + 11'h001)
        else $error("position did not advance by one");
    a_stored_exec: assert property (
        take && prg_cmd != PES_CMD_STOP |=> exec_valid && exec_stored)
        else $error("taken stored command not executed");

    c_run_take: cover property (mode == PES_ST_RUN && take);
    c_step_take: cover property (mode == PES_ST_STEP && take);
    c_wrap: cover property (line_warn);
endmodule : pes_seq_properties

bind pes_seq pes_seq_properties u_props (
    .sys_clk(sys_clk), .resetn(resetn), .dir_valid(dir_valid),
    .dir_cmd(dir_cmd), .prg_valid(prg_valid), .prg_cmd(prg_cmd),
    .prog_stored(prog_stored), .exec_error(exec_error),
    .exec_warn(exec_warn), .prg_ready(prg_ready), .prg_pos(prg_pos),
    .exec_valid(exec_valid), .exec_stored(exec_stored), .mode(mode),
    .line_close(line_close), .line_warn(line_warn));

// [verification/pes_prog_mem.sv]
// Program memory model offering stored commands by position
`timescale 1ns/1ps
module pes_prog_mem
    import pes_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Pace control
    input wire logic slow,
    // Stored command port
    input wire logic prg_ready,
    input wire logic [PES_PC_W-1:0] prg_pos,
    output logic prg_valid,
    output pes_cmd_e prg_cmd,
    output logic [PES_MNEM_W-1:0] prg_len
);
    logic [1:0] wait_q;
    logic [3:0] junk_q = 4'h0;
    // Gap after each take when slow; offer held until taken
    always_ff @(posedge sys_clk)
    begin
        junk_q <= junk_q + 4'h1;
        if (!resetn)
            wait_q <= 2'h0;
        else if (prg_valid && prg_ready)
            wait_q <= slow ? 2'h3 : 2'h0;
        else if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
    end
    // Eight-entry program ending in STOP, noise when nothing offered
    assign prg_valid = (wait_q == 2'h0);
    assign prg_cmd = !prg_valid ? pes_cmd_e'(junk_q) :
        (prg_pos[2:0] == 3'h7) ? PES_CMD_STOP :
        prg_pos[0] ? PES_CMD_NUMERIC : PES_CMD_OTHER;
    assign prg_len = prg_valid ? 3'h2 : junk_q[2:0];
endmodule : pes_prog_mem

// [verification/pes_seq_bench.sv]
// Self-checking bench for the program execute sequencer
`timescale 1ns/1ps
module pes_seq_bench;
    import pes_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic dir_valid = 1'b0;
    pes_cmd_e dir_cmd = PES_CMD_OTHER;
    logic [PES_MNEM_W-1:0] dir_len = 3'h0;
    logic prog_stored = 1'b0, exec_error = 1'b0, exec_warn = 1'b0;
    logic slow = 1'b0, prg_valid, prg_ready, exec_valid, exec_stored;
    logic store_valid, store_space, busy, line_close, line_warn;
    pes_cmd_e prg_cmd, exec_cmd, store_cmd;
    logic [PES_MNEM_W-1:0] prg_len;
    logic [PES_PC_W-1:0] prg_pos;
    pes_state_e mode;
    logic [PES_LEN_W-1:0] line_len;
    logic [PES_LNUM_W-1:0] line_num;
    int fail_count = 0, compares = 0, n_dir = 0, cyc = 0;
    int elen = 0, enr = 0, i, base;
    logic pnum = 1'b0;
    logic [31:0] r = 32'hbe0b_9498;

    // ****************************************************************
    // Design, partner and clock
    // ****************************************************************
    pes_seq #(.LINE_MAX(PES_LINE_MAX)) uut (
        .sys_clk(sys_clk), .resetn(resetn), .dir_valid(dir_valid),
        .dir_cmd(dir_cmd), .dir_len(dir_len), .prg_valid(prg_valid),
        .prg_cmd(prg_cmd), .prg_len(prg_len), .prg_ready(prg_ready),
        .prg_pos(prg_pos), .prog_stored(prog_stored),
        .exec_error(exec_error), .exec_warn(exec_warn),
        .exec_valid(exec_valid), .exec_cmd(exec_cmd),
        .exec_stored(exec_stored), .store_valid(store_valid),
        .store_cmd(store_cmd), .store_space(store_space), .mode(mode),
        .busy(busy), .line_len(line_len), .line_num(line_num),
        .line_close(line_close), .line_warn(line_warn));
    pes_prog_mem partner (.sys_clk(sys_clk), .resetn(resetn),
        .slow(slow), .prg_ready(prg_ready), .prg_pos(prg_pos),
        .prg_valid(prg_valid), .prg_cmd(prg_cmd), .prg_len(prg_len));
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Direct execution pulses and cycle ceiling
    always @(negedge sys_clk)
    begin
        cyc++;
        if (exec_valid === 1'b1 && exec_stored === 1'b0)
            n_dir++;
        if (cyc == 5000)
        begin
            fail_count++;
            end_sim();
        end
    end

    // ****************************************************************
    // Tasks and functions
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (exp !== got)
        begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic send(input pes_cmd_e c, input logic [2:0] l);
        @(negedge sys_clk);
        dir_valid = 1'b1;
        dir_cmd = c;
        dir_len = l;
    endtask : send
    task automatic quiet();
        @(negedge sys_clk);
        dir_valid = 1'b0;
        dir_cmd = pes_cmd_e'(~dir_cmd);
        dir_len = ~dir_len;
    endtask : quiet
    task automatic go(input pes_cmd_e c, input pes_state_e m);
        send(c, 3'h3);
        quiet();
        chk("mode", m, mode);
    endtask : go
    task automatic evt(input logic e, input logic w);
        @(negedge sys_clk);
        exec_error = e;
        exec_warn = w;
        @(negedge sys_clk);
        exec_error = 1'b0;
        exec_warn = 1'b0;
        chk("mode", PES_ST_IDLE, mode);
    endtask : evt
    // One entry command against the line model
    task automatic ent(input logic num, input logic [2:0] l);
        logic sp;
        logic wrap;
        pes_cmd_e c;
        c = num ? PES_CMD_NUMERIC : PES_CMD_OTHER;
        sp = (elen != 0) && !(num && pnum);
        wrap = (elen + sp + l) > PES_LINE_MAX;
        send(c, l);
        quiet();
        elen = wrap ? l : elen + sp + l;
        enr = enr + wrap;
        pnum = num;
        chk("store_valid", 1, store_valid);
        chk("store_cmd", c, store_cmd);
        chk("store_space", sp && !wrap, store_space);
        chk("line_warn", wrap, line_warn);
        chk("line_close", wrap, line_close);
        chk("line_len", elen, line_len);
        chk("line_num", enr, line_num);
    endtask : ent
    task automatic nxt();
        logic cl;
        cl = elen != 0;
        send(PES_CMD_NEXT, 3'h4);
        quiet();
        enr = enr + cl;
        elen = 0;
        chk("line_close", cl, line_close);
        chk("line_num", enr, line_num);
        chk("line_len", 0, line_len);
    endtask : nxt
    task automatic end_sim();
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        chk("mode", PES_ST_IDLE, mode);
        go(PES_CMD_RUN, PES_ST_IDLE);
        go(PES_CMD_STEP, PES_ST_IDLE);
        base = n_dir;
        go(PES_CMD_OTHER, PES_ST_IDLE);
        chk("exec_cmd", PES_CMD_OTHER, exec_cmd);
        repeat (2) @(posedge sys_clk);
        chk("direct exec", base + 1, n_dir);
        chk("prg_pos", 0, prg_pos);
        go(PES_CMD_PROG, PES_ST_ENTRY);
        for (i = 0; i < 60; i++)
        begin
            r = lfsr(r);
            ent(r[0], 3'(r[3:1] % 5 + 1));
        end
        nxt();
        nxt();
        // Exactly full line, then one more wraps
        for (i = 0; i < 6; i++)
            ent(1'b0, 3'h5);
        ent(1'b1, 3'h1);
        nxt();
        // Back-to-back mnemonics, numeric pair joined
        send(PES_CMD_OTHER, 3'h2);
        send(PES_CMD_NUMERIC, 3'h1);
        send(PES_CMD_NUMERIC, 3'h1);
        quiet();
        chk("line_len", 5, line_len);
        elen = 5;
        nxt();
        go(PES_CMD_EXECUTE, PES_ST_IDLE);
        chk("line_len", 0, line_len);
        prog_stored = 1'b1;
        go(PES_CMD_PROG, PES_ST_EDIT);
        go(PES_CMD_EXECUTE, PES_ST_IDLE);
        slow = 1'b1;
        go(PES_CMD_RUN, PES_ST_RUN);
        chk("busy", 1, busy);
        @(posedge sys_clk);
        base = n_dir;
        go(PES_CMD_OTHER, PES_ST_RUN);
        repeat (2) @(posedge sys_clk);
        chk("direct exec", base, n_dir);
        go(PES_CMD_STOP, PES_ST_IDLE);
        go(PES_CMD_RUN, PES_ST_RUN);
        evt(1'b1, 1'b0);
        slow = 1'b0;
        go(PES_CMD_RUN, PES_ST_RUN);
        for (i = 0; i < 50 && mode !== PES_ST_IDLE; i++)
            @(posedge sys_clk);
        chk("mode", PES_ST_IDLE, mode);
        chk("prg_pos", 8, prg_pos);
        go(PES_CMD_STEP, PES_ST_STEP);
        repeat (6) @(posedge sys_clk);
        chk("prg_pos", 9, prg_pos);
        go(PES_CMD_STEP, PES_ST_STEP);
        repeat (6) @(posedge sys_clk);
        chk("prg_pos", 10, prg_pos);
        evt(1'b0, 1'b1);
        end_sim();
    end
endmodule : pes_seq_bench
